/* hw/siop_pkg.sv */
// Constants for the six-bit I/O port latch.
// Assumes an Avalon-MM slave with byte addresses and 32-bit data.
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package siop_pkg;
  localparam logic [7:0] SIOP_PORT_OFFSET = 8'h10;
  localparam int SIOP_PULLUP_BIT = 7;
  localparam logic [1:0] SIOP_LATCH_RESET = 2'h3;
  localparam logic SIOP_PULLUP_RESET = 1'b0;
  localparam int SIOP_SYNC_STAGES = 3;
  localparam int SIOP_PIN_COUNT = 6;
  localparam int SIOP_LATCH_LSB = 2;
  localparam int SIOP_LATCH_MSB = 3;
  localparam logic SIOP_WAIT_RESET = 1'h1;
  localparam logic SIOP_PULLUP_EN_RESET = 1'h1;
  localparam logic [5:0] SIOP_OE_RESET = 6'h00;
  localparam logic [5:0] SIOP_OUT_RESET = 6'h00;
endpackage

/* hw/siop_port.sv */
// Six-bit I/O port latch with Avalon-MM register access.
// Assumes pins arrive asynchronously and peripherals run on sys_clk.
`timescale 1ns/100ps
module siop_port
  import siop_pkg::*;
#(
  parameter int PIN_COUNT = SIOP_PIN_COUNT,
  parameter int SYNC_STAGES = SIOP_SYNC_STAGES
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [PIN_COUNT-1:0] pin_in,
  output logic [PIN_COUNT-1:0] pin_out,
  output logic [PIN_COUNT-1:0] pin_oe,
  input wire logic sync_serial_port_en,
  input wire logic sync_serial_port_pin_two_oe,
  input wire logic sync_serial_port_pin_three_oe,
  input wire logic first_usart_en,
  input wire logic usart_receive_or_sync_data_oe,
  input wire logic usart_receive_or_sync_data_out,
  input wire logic usart_transmit_or_sync_clock_oe,
  input wire logic usart_transmit_or_sync_clock_out,
  output logic pin_zero_level,
  output logic timer_zero_clock_input,
  output logic second_port_pullup_en
);
  import siop_pkg::*;

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  // The pin map is fixed: two inputs, two open-drain pins, two USART pins
  if (PIN_COUNT != SIOP_PIN_COUNT)
  begin : g_pin_count_check
    $error("siop_port: PIN_COUNT must be six");
  end
  // Fewer than three stages leaves no settled pair of stages to compare
  if (SYNC_STAGES < SIOP_SYNC_STAGES)
  begin : g_sync_depth_check
    $error("siop_port: SYNC_STAGES must be at least three");
  end

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic {SIOP_BUS_IDLE, SIOP_BUS_ANSWER} siop_bus_e;

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  siop_bus_e bus_state_reg;
  siop_bus_e bus_state_next;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [1:0] latch_reg;
  logic pullup_ctrl_reg;
  logic pullup_en_reg;
  logic [PIN_COUNT-1:0] level_reg;
  logic [PIN_COUNT-1:0] oe_reg;
  logic [PIN_COUNT-1:0] out_reg;
  logic level0_reg;
  logic level1_reg;

  // ------------------------------------------------------------
  // Named decode nets
  // ------------------------------------------------------------
  wire logic bus_request;
  wire logic bus_answer;
  wire logic write_take;
  wire logic read_load;
  wire logic wait_next;
  wire logic [1:0] latch_next;
  wire logic pullup_ctrl_next;
  wire logic [7:0] port_view;
  wire logic [31:0] rdata_next;
  wire logic oe_two;
  wire logic oe_three;
  wire logic oe_four;
  wire logic oe_five;
  wire logic [PIN_COUNT-1:0] oe_next;
  wire logic [PIN_COUNT-1:0] out_next;
  wire logic [PIN_COUNT-1:0] level_next;

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  // Address decode is shared by the write and the read path
  function automatic logic siop_addr_hit(input logic [7:0] addr);
    siop_addr_hit = addr == SIOP_PORT_OFFSET;
  endfunction

  // Open drain: the latch can only pull low, a live serial port overrides it
  function automatic logic siop_drain_oe(
    input logic periph_en,
    input logic periph_oe,
    input logic latch_bit
  );
    siop_drain_oe = periph_en ? periph_oe : ~latch_bit;
  endfunction

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  assign bus_request = avs_read | avs_write;
  assign bus_answer = bus_state_reg == SIOP_BUS_ANSWER;
  // A write lands only at the edge where waitrequest is seen low
  assign write_take = avs_write & bus_answer & avs_byteenable[0]
    & siop_addr_hit(avs_address);
  // Read data is captured in the wait cycle so it stands registered
  assign read_load = avs_read & ~bus_answer;
  assign wait_next = bus_state_next != SIOP_BUS_ANSWER;

  // ------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------
  always_comb
  begin
    bus_state_next = bus_state_reg;
    unique case (bus_state_reg)
      SIOP_BUS_IDLE:
      begin
        if (bus_request)
        begin
          bus_state_next = SIOP_BUS_ANSWER;
        end
      end
      SIOP_BUS_ANSWER:
      begin
        // Master releases here, so no request is taken twice
        bus_state_next = SIOP_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      bus_state_reg <= SIOP_BUS_IDLE;
    end
    else
    begin
      bus_state_reg <= bus_state_next;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      wait_reg <= SIOP_WAIT_RESET;
    end
    else
    begin
      wait_reg <= wait_next;
    end
  end

  // ------------------------------------------------------------
  // Pin synchroniser
  // ------------------------------------------------------------
  // Not reset: pin levels are unknown until they settle anyway
  genvar pin_i;
  generate
    for (pin_i = 0; pin_i < PIN_COUNT; pin_i++)
    begin : g_pin_sync
      logic [SYNC_STAGES-1:0] chain_reg;
      // Last two stages must agree, so a level caught mid-edge is not taken
      assign level_next[pin_i] =
        (chain_reg[SYNC_STAGES-1] == chain_reg[SYNC_STAGES-2])
        ? chain_reg[SYNC_STAGES-1] : level_reg[pin_i];
      always_ff @(posedge sys_clk)
      begin
        chain_reg <= {chain_reg[SYNC_STAGES-2:0], pin_in[pin_i]};
      end
    end
  endgenerate

  always_ff @(posedge sys_clk)
  begin
    level_reg <= level_next;
  end

  // ------------------------------------------------------------
  // Port latch and pull-up control
  // ------------------------------------------------------------
  // Only bits three and two are stored for pins, plus bit seven for pull-up control; other pins have no latch
  assign latch_next = write_take ? avs_writedata[SIOP_LATCH_MSB:SIOP_LATCH_LSB]
    : latch_reg;
  assign pullup_ctrl_next = write_take ? avs_writedata[SIOP_PULLUP_BIT]
    : pullup_ctrl_reg;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      latch_reg <= SIOP_LATCH_RESET;
    end
    else
    begin
      latch_reg <= latch_next;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      pullup_ctrl_reg <= SIOP_PULLUP_RESET;
    end
    else
    begin
      pullup_ctrl_reg <= pullup_ctrl_next;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      pullup_en_reg <= SIOP_PULLUP_EN_RESET;
    end
    else
    begin
      pullup_en_reg <= ~pullup_ctrl_reg;
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  // Read shows pins, not the latch; bit six reads zero
  assign port_view = {pullup_ctrl_reg, 1'b0, level_reg};
  assign rdata_next = ~read_load ? rdata_reg
    : siop_addr_hit(avs_address) ? {24'h0, port_view} : 32'h0;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      rdata_reg <= 32'h0;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  assign oe_two = siop_drain_oe(sync_serial_port_en, sync_serial_port_pin_two_oe,
    latch_reg[0]);
  assign oe_three = siop_drain_oe(sync_serial_port_en, sync_serial_port_pin_three_oe,
    latch_reg[1]);
  // USART alone drives pins four and five; disabled it floats them
  assign oe_four = first_usart_en & usart_receive_or_sync_data_oe;
  assign oe_five = first_usart_en & usart_transmit_or_sync_clock_oe;
  // Pins zero and one never drive: no direction bit exists to turn them
  assign oe_next = {oe_five, oe_four, oe_three, oe_two, 2'h0};
  // Open-drain pins only ever pull low, so their data is fixed at zero
  assign out_next = {usart_transmit_or_sync_clock_out, usart_receive_or_sync_data_out,
    4'h0};

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      oe_reg <= SIOP_OE_RESET;
    end
    else
    begin
      oe_reg <= oe_next;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      out_reg <= SIOP_OUT_RESET;
    end
    else
    begin
      out_reg <= out_next;
    end
  end

  // ------------------------------------------------------------
  // Alternate input functions
  // ------------------------------------------------------------
  // Costs one cycle over the filtered level, but keeps outputs on flops
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      level0_reg <= 1'b0;
    end
    else
    begin
      level0_reg <= level_reg[0];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      level1_reg <= 1'b0;
    end
    else
    begin
      level1_reg <= level_reg[1];
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
  assign pin_oe = oe_reg;
  assign pin_out = out_reg;
  assign pin_zero_level = level0_reg;
  assign timer_zero_clock_input = level1_reg;
  assign second_port_pullup_en = pullup_en_reg;
endmodule

/* sim/siop_pins.sv */
// Pad model: outside drivers and pull-ups.
// Assumes the port drives pin_out only where pin_oe is high.
`timescale 1ns/100ps
module siop_pins (
  input wire logic [5:0] pin_out, pin_oe, ext_en, ext_val,
  output logic [5:0] pin_in);
  assign pin_in = pin_oe & pin_out | ~pin_oe & (ext_en & ext_val | ~ext_en);
endmodule

/* sim/siop_port_asserts.sv */
// Port checker, bound from the bench top.
// Assumes single-cycle answers as the port's bus contract gives.
`timescale 1ns/100ps
module siop_port_asserts (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic second_port_pullup_en,
  input wire logic [7:0] avs_address,
  input wire logic [3:0] avs_byteenable,
  input wire logic [5:0] pin_oe,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire rok = avs_read & !avs_waitrequest;
  reset_pins_a: assert property ($rose(reset_n) |-> !pin_oe && second_port_pullup_en)
    else $error("reset");
  fixed_dir_a: assert property (!pin_oe[1:0]) else $error("dir");
  pullup_ctl_a: assert property (avs_write && !avs_waitrequest && avs_address == 8'h10
    && avs_byteenable[0]
    |=> ##1 second_port_pullup_en ^ $past(avs_writedata[7], 2)) else $error("pullup");
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait");
  read_spare_a: assert property (rok |-> !avs_readdata[31:8] && !avs_readdata[6])
    else $error("spare");
  read_unmapped_a: assert property (rok && avs_address != 8'h10 |-> !avs_readdata)
    else $error("unmapped");
endmodule

/* sim/siop_port_bench.sv */
// Bench for siop_port with the pad model.
// Byte enables ride on write data bits 11:8.
`timescale 1ns/100ps
module siop_port_bench;
  logic sys_clk = 0, reset_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest, pu, zl, tz;
  logic [7:0] avs_address = 0, q;
  logic [31:0] avs_writedata = 0, avs_readdata;
  logic [5:0] pin_in, pin_out, pin_oe, pv = 0;
  int n_fail = 0, n_compared = 0, cyc = 0;
  siop_port dut_u (.*, .avs_byteenable(avs_writedata[11:8]), .sync_serial_port_en(pv[0]),
    .sync_serial_port_pin_two_oe(pv[1]), .sync_serial_port_pin_three_oe(pv[2]),
    .first_usart_en(pv[3]), .usart_receive_or_sync_data_oe(pv[4]),
    .usart_receive_or_sync_data_out(pv[4]), .usart_transmit_or_sync_clock_oe(pv[5]),
    .usart_transmit_or_sync_clock_out(1'b0), .pin_zero_level(zl),
    .timer_zero_clock_input(tz), .second_port_pullup_en(pu));
  siop_pins pads_u (.pin_out, .pin_oe, .ext_en(6'h33), .ext_val(6'h21), .pin_in);
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk) {avs_read, avs_write, avs_address, avs_writedata} <= {!w, w, a, d};
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    {avs_read, avs_write} <= 0;
  endtask
  task chk(input string s, input logic [7:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s exp %h got %h", s, e, g);
    end
  endtask
  task close_out;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (!n_fail && n_compared) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task t_port;
    acc(0, 8'h10, 0); chk("port", 8'h2D, q);
    chk("oe", 8'h80, {pu, 1'b0, pin_oe});
    acc(1, 8'h10, 32'h183); repeat (6) @(posedge sys_clk);
    acc(0, 8'h10, 0); chk("port", 8'hA1, q);
    acc(1, 8'h11, 32'h100); acc(0, 8'h11, 0); chk("spare", 8'h00, q);
  endtask
  // Peripherals take pins 2 to 5 over with no direction bits
  task t_periph;
    pv <= 6'h3B; repeat (6) @(posedge sys_clk);
    acc(0, 8'h10, 0); chk("port", 8'h99, q);
    chk("oe", 8'h34, {pu, 1'b0, pin_oe});
    chk("alt", 8'h01, {tz, zl});
  endtask
  // Mid-run reset: peripherals reset with the port, so every pin floats
  task t_reset;
    pv <= 0;
    reset_n <= 0;
    repeat (20) @(posedge sys_clk);
    chk("oe", 8'h80, {pu, 1'b0, pin_oe});
    reset_n <= 1;
    acc(0, 8'h10, 0); chk("port", 8'h2D, q);
  endtask
  initial forever #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    if (++cyc == 3000)
    begin
      n_fail++;
      close_out;
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1;
    t_port;
    t_periph;
    t_reset;
    close_out;
  end
endmodule
bind siop_port siop_port_asserts chk_u (.*);
